// file: pwr_pkg.sv
package pwr_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] SUPPLY_MONITOR_CONTROL_ADDR = 4'h0;
  localparam logic [3:0] POWER_MODE_REQUEST_ADDR     = 4'h1;
  localparam logic [3:0] POWER_MODE_CLEAR_ADDR       = 4'h2;
  localparam logic [3:0] CLOCK_CONFIG_ADDR           = 4'h3;
  localparam logic [3:0] MODE_STATUS_ADDR            = 4'h4;
  // field positions
  localparam int LOW_SUPPLY_FLAG_BIT  = 0;
  localparam int TRIM_LSB             = 5;
  localparam int HALT_REQUEST_BIT     = 0;
  localparam int IDLE_REQUEST_BIT     = 1;
  localparam int CLOCK_SOURCE_LSB     = 0;
  // reset values
  localparam logic [2:0] TRIM_RESET         = 3'h0;
  localparam logic [1:0] CLOCK_SOURCE_RESET = 2'h0;
  localparam logic [7:0] IO_RESET           = 8'h00;
  // clock source codes, bit0 first as listed
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_SQUARE   = 2'h1;
  localparam logic [1:0] CLK_CRYSTAL  = 2'h2;
  localparam logic [1:0] CLK_RC       = 2'h3;
  // timing
  localparam int CLK_PERIOD_NS          = 40;
  localparam int HALT_STARTUP_CYCLES    = 64;
  localparam int IDLE_TIMER_CYCLES      = 8192;
  localparam int MONITOR_SETTLE_US      = 10;
  localparam int MONITOR_SETTLE_CYCLES  = (MONITOR_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_STARTUP_CYCLES   = 64;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_HALT  = 3'b010,
    ST_IDLE  = 3'b100
  } pmode_t;
endpackage

// file: power_mode_supply_monitor.sv
`timescale 1ns/1ps
module power_mode_supply_monitor
  import pwr_pkg::*;
#(
  parameter int IDLE_PERIOD = IDLE_TIMER_CYCLES
) (
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_B_IN,
  input  wire logic [3:0] ADDR_IN,
  input  wire logic [7:0] WDATA_IN,
  input  wire logic       WR_IN,
  input  wire logic       RD_IN,
  output logic      [7:0] RDATA_OUT,
  input  wire logic       BELOW_THRESHOLD_IN,
  input  wire logic       POWER_ON_DETECT_IN,
  input  wire logic       BROWNOUT_DETECT_IN,
  input  wire logic       WATCHDOG_EXPIRE_IN,
  input  wire logic       BROWNOUT_ENABLE_IN,
  input  wire logic       MULTI_INPUT_WAKEUP_IN,
  output logic      [2:0] THRESHOLD_SELECT_OUT,
  output logic            MONITOR_ENABLE_OUT,
  output logic            BROWNOUT_ACTIVE_OUT,
  output logic            OSC_ENABLE_OUT,
  output logic      [1:0] CLOCK_SOURCE_OUT,
  output logic      [2:0] CLOCK_DIVIDE_OUT,
  output logic            CPU_RUN_OUT,
  output logic            TIMER_RUN_OUT,
  output logic            IO_RESET_OUT,
  output logic            SYSTEM_RESET_OUT,
  output logic            LOW_SUPPLY_VALID_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] below_sync;
  logic [1:0] por_sync;
  logic [1:0] bod_sync;
  logic [1:0] wdt_sync;
  logic [1:0] wake_sync;
  logic [1:0] brownout_enable_sync;

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      below_sync <= 2'h0;
    end else begin
      below_sync <= {below_sync[0], BELOW_THRESHOLD_IN};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      por_sync <= 2'h0;
    end else begin
      por_sync <= {por_sync[0], POWER_ON_DETECT_IN};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      bod_sync <= 2'h0;
    end else begin
      bod_sync <= {bod_sync[0], BROWNOUT_DETECT_IN};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      wdt_sync <= 2'h0;
    end else begin
      wdt_sync <= {wdt_sync[0], WATCHDOG_EXPIRE_IN};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      wake_sync <= 2'h0;
    end else begin
      wake_sync <= {wake_sync[0], MULTI_INPUT_WAKEUP_IN};
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      brownout_enable_sync <= 2'h0;
    end else begin
      brownout_enable_sync <= {brownout_enable_sync[0], BROWNOUT_ENABLE_IN};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing
  pmode_t     mode;
  logic       reset_req;
  logic [6:0] reset_count;
  logic       brownout_active;

  // brown-out only counts when the non-volatile enable is set and the detector runs
  assign brownout_active = brownout_enable_sync[1] && (mode == ST_RUN);
  assign reset_req = por_sync[1] || (brownout_active && bod_sync[1]) || wdt_sync[1];

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      reset_count <= 7'(RESET_STARTUP_CYCLES);
    end else if (reset_req) begin
      reset_count <= 7'(RESET_STARTUP_CYCLES);
    end else if (reset_count != 7'h00) begin
      reset_count <= reset_count - 7'h01;
    end
  end

  logic sys_reset;
  assign sys_reset = reset_req || (reset_count != 7'h00);

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  logic [2:0] trim;
  logic [1:0] clock_source;
  logic       wr_ctrl;
  logic       wr_req;
  logic       wr_clr;
  logic       wr_clk;
  assign wr_ctrl = WR_IN && (ADDR_IN == SUPPLY_MONITOR_CONTROL_ADDR);
  assign wr_req  = WR_IN && (ADDR_IN == POWER_MODE_REQUEST_ADDR);
  assign wr_clr  = WR_IN && (ADDR_IN == POWER_MODE_CLEAR_ADDR);
  assign wr_clk  = WR_IN && (ADDR_IN == CLOCK_CONFIG_ADDR);

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN || sys_reset) begin
      trim <= TRIM_RESET;
    end else if (wr_ctrl) begin
      trim <= WDATA_IN[TRIM_LSB +: 3];
    end
  end

  // clock source sits in the initialization register; only RST_B_IN resets it, system reset does not alter it
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      clock_source <= CLOCK_SOURCE_RESET;
    end else if (wr_clk) begin
      clock_source <= WDATA_IN[CLOCK_SOURCE_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power modes
  logic [6:0]  startup_count;
  logic [13:0] idle_count;
  logic        mode_exited;
  logic        idle_overflow;
  assign idle_overflow = (idle_count == 14'(IDLE_PERIOD - 1));

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN || sys_reset) begin
      mode          <= ST_RUN;
      startup_count <= 7'h00;
      mode_exited   <= 1'b0;
    end else begin
      case (mode)
        ST_RUN: begin
          if (startup_count != 7'h00) begin
            startup_count <= startup_count - 7'h01;
          end
          if (wr_clr) begin
            mode_exited <= 1'b0;
          end
          if (wr_req && startup_count == 7'h00) begin
            if (WDATA_IN[HALT_REQUEST_BIT]) begin
              mode <= ST_HALT;
            end else if (WDATA_IN[IDLE_REQUEST_BIT]) begin
              mode <= ST_IDLE;
            end
          end
        end
        ST_HALT: begin
          if (wake_sync[1]) begin
            mode          <= ST_RUN;
            startup_count <= 7'(HALT_STARTUP_CYCLES);
            mode_exited   <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (idle_overflow || wake_sync[1]) begin
            mode        <= ST_RUN;
            mode_exited <= 1'b1;
          end
        end
        default: mode <= ST_RUN;
      endcase
    end
  end

  // timer 0 keeps counting except in halt
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN || sys_reset) begin
      idle_count <= 14'h0000;
    end else if (mode == ST_HALT) begin
      idle_count <= idle_count;
    end else if (idle_overflow) begin
      idle_count <= 14'h0000;
    end else begin
      idle_count <= idle_count + 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply monitor
  logic        low_supply_flag;
  logic [8:0]  settle_count;
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN || sys_reset) begin
      low_supply_flag <= 1'b0;
    end else if (mode == ST_RUN) begin
      low_supply_flag <= below_sync[1];
    end
  end

  // flag is only trustworthy after the comparator has settled
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN || sys_reset) begin
      settle_count <= 9'h000;
    end else if (mode != ST_RUN) begin
      settle_count <= 9'(MONITOR_SETTLE_CYCLES);
    end else if (settle_count != 9'h000) begin
      settle_count <= settle_count - 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock selection
  function automatic logic [2:0] divide_for(input logic [1:0] src);
    case (src)
      CLK_INTERNAL: divide_for = 3'h2;
      CLK_SQUARE:   divide_for = 3'h1;
      default:      divide_for = 3'h4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // read port; request register is write-only and reads zero
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      if (ADDR_IN == SUPPLY_MONITOR_CONTROL_ADDR) begin
        RDATA_OUT <= {trim, 4'h0, low_supply_flag};
      end else if (ADDR_IN == CLOCK_CONFIG_ADDR) begin
        RDATA_OUT <= {6'h00, clock_source};
      end else if (ADDR_IN == MODE_STATUS_ADDR) begin
        RDATA_OUT <= {4'h0, (settle_count == 9'h000), mode_exited, mode == ST_IDLE, mode == ST_HALT};
      end else begin
        RDATA_OUT <= 8'h00;
      end
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; flag drives nothing but the read path
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      THRESHOLD_SELECT_OUT <= TRIM_RESET;
    end else begin
      THRESHOLD_SELECT_OUT <= trim;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      MONITOR_ENABLE_OUT <= 1'b0;
    end else begin
      MONITOR_ENABLE_OUT <= (mode == ST_RUN) && !sys_reset;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      BROWNOUT_ACTIVE_OUT <= 1'b0;
    end else begin
      BROWNOUT_ACTIVE_OUT <= brownout_active;
    end
  end

  // registered so a mode change cannot glitch the oscillator gate
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      OSC_ENABLE_OUT <= 1'b1;
    end else begin
      OSC_ENABLE_OUT <= (mode != ST_HALT) && (clock_source == CLK_INTERNAL);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      CLOCK_SOURCE_OUT <= CLOCK_SOURCE_RESET;
    end else begin
      CLOCK_SOURCE_OUT <= clock_source;
    end
  end

  // divider follows the stored source, so a system reset keeps the running clock
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      CLOCK_DIVIDE_OUT <= 3'h2;
    end else begin
      CLOCK_DIVIDE_OUT <= divide_for(clock_source);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      CPU_RUN_OUT <= 1'b0;
    end else begin
      CPU_RUN_OUT <= (mode == ST_RUN) && (startup_count == 7'h00) && !sys_reset;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      TIMER_RUN_OUT <= 1'b0;
    end else begin
      TIMER_RUN_OUT <= (mode != ST_HALT) && !sys_reset;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      IO_RESET_OUT <= 1'b1;
    end else begin
      IO_RESET_OUT <= sys_reset;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      SYSTEM_RESET_OUT <= 1'b1;
    end else begin
      SYSTEM_RESET_OUT <= sys_reset;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_B_IN) begin
      LOW_SUPPLY_VALID_OUT <= 1'b0;
    end else begin
      LOW_SUPPLY_VALID_OUT <= (mode == ST_RUN) && (settle_count == 9'h000);
    end
  end

endmodule

// file: pwr_monitor.sv
`timescale 1ns/1ps
module pwr_monitor
  import pwr_pkg::*;
(
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_B_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic       WR_IN,
  input wire logic       RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       WATCHDOG_EXPIRE_IN,
  input wire logic [2:0] THRESHOLD_SELECT_OUT,
  input wire logic       OSC_ENABLE_OUT,
  input wire logic [1:0] CLOCK_SOURCE_OUT,
  input wire logic [2:0] CLOCK_DIVIDE_OUT,
  input wire logic       CPU_RUN_OUT,
  input wire logic       TIMER_RUN_OUT,
  input wire logic       IO_RESET_OUT,
  input wire logic       SYSTEM_RESET_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  ////////////////////////////////////////////////////////////////////////////////
  a_read_slot_zero: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (RD_IN && ADDR_IN > MODE_STATUS_ADDR |=> RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_request_reads_zero: assert property (RD_IN && ADDR_IN == POWER_MODE_REQUEST_ADDR |=> RDATA_OUT == 8'h00)
    else $error("write-only request readable");
  a_bit4_zero: assert property (RD_IN && ADDR_IN == SUPPLY_MONITOR_CONTROL_ADDR |=> RDATA_OUT[4:1] == 4'h0)
    else $error("monitor control bits 4..1 not zero");
  a_trim_follows: assert property (WR_IN && ADDR_IN == SUPPLY_MONITOR_CONTROL_ADDR && !SYSTEM_RESET_OUT
    |-> ##2 THRESHOLD_SELECT_OUT == 3'($past(WDATA_IN, 2) >> 5))
    else $error("threshold select not taken");
  a_divide_match: assert property ((CLOCK_SOURCE_OUT == CLK_INTERNAL) == (CLOCK_DIVIDE_OUT == 3'h2)
    && (CLOCK_SOURCE_OUT == CLK_SQUARE) == (CLOCK_DIVIDE_OUT == 3'h1))
    else $error("divider does not match source");
  a_halt_osc_off: assert property (!TIMER_RUN_OUT && !$past(TIMER_RUN_OUT) && !SYSTEM_RESET_OUT
    && !$past(SYSTEM_RESET_OUT) |-> !OSC_ENABLE_OUT)
    else $error("oscillator runs in halt");
  // antecedent needs cpu low so a plain source switch back to internal is not taken
  a_halt_startup: assert property ($rose(OSC_ENABLE_OUT) && !CPU_RUN_OUT && !SYSTEM_RESET_OUT
    |-> ##62 !CPU_RUN_OUT ##[1:12] CPU_RUN_OUT)
    else $error("halt start-up delay wrong");
  a_watchdog_reset: assert property ($rose(WATCHDOG_EXPIRE_IN) |-> ##[1:5] (SYSTEM_RESET_OUT && IO_RESET_OUT))
    else $error("watchdog did not reset");
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb
  import pwr_pkg::*;
;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, below = 0, bo_en = 0, wake = 0, rd_q = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, e;
  logic [2:0] src = 3'h0, thr, div, tv;
  logic [1:0] csrc;
  logic       mon, boa, osc, cpu, tmr, ior, sysr, lsv;
  logic [7:0] exp_q[$];
  int         fail_count = 0, checks = 0, cyc = 0, n, i;
  power_mode_supply_monitor #(.IDLE_PERIOD(IDLE_TIMER_CYCLES)) dut (.CORE_CLK_IN(clk), .RST_B_IN(rst_b),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BELOW_THRESHOLD_IN(below),
    .POWER_ON_DETECT_IN(src[0]), .BROWNOUT_DETECT_IN(src[1]), .WATCHDOG_EXPIRE_IN(src[2]),
    .BROWNOUT_ENABLE_IN(bo_en), .MULTI_INPUT_WAKEUP_IN(wake), .THRESHOLD_SELECT_OUT(thr),
    .MONITOR_ENABLE_OUT(mon), .BROWNOUT_ACTIVE_OUT(boa), .OSC_ENABLE_OUT(osc), .CLOCK_SOURCE_OUT(csrc),
    .CLOCK_DIVIDE_OUT(div), .CPU_RUN_OUT(cpu), .TIMER_RUN_OUT(tmr), .IO_RESET_OUT(ior),
    .SYSTEM_RESET_OUT(sysr), .LOW_SUPPLY_VALID_OUT(lsv));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1; exp_q.push_back(d);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // bounded wait so a stuck mode cannot hang the run
  task automatic wait_lv(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin @(posedge clk); k++; end
    chk(8'(k < lim), 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_q) begin e = exp_q.pop_front(); chk(rdata, e); end
    rd_q <= rd;
    cyc++;
    if (cyc == 20000) begin fail_count++; summarize; end
  end
  initial begin
    n = $urandom(5);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1; bo_en <= 1'b1; below <= 1'b1;
    wait_lv(sysr, 1'b0, 200, n);
    for (i = 0; i < 4; i++) begin
      tv = 3'($urandom % 8);
      wr_reg(SUPPLY_MONITOR_CONTROL_ADDR, {tv, 5'h1F});
      rd_reg(SUPPLY_MONITOR_CONTROL_ADDR, {tv, 4'h0, 1'b1});
      chk(8'(thr), 8'(tv));
    end
    below <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(SUPPLY_MONITOR_CONTROL_ADDR, {tv, 5'h00});
    rd_reg(4'hF, 8'h00);
    rd_reg(POWER_MODE_REQUEST_ADDR, 8'h00);
    chk(8'({lsv, ior, mon, boa, osc, tmr, cpu}), 8'h5F);
    // overflow exit first; it restarts timer 0, so the wake-up pass below cannot be cut short
    wr_reg(POWER_MODE_REQUEST_ADDR, 8'h02);
    wait_lv(cpu, 1'b0, 4, n);
    wait_lv(cpu, 1'b1, IDLE_TIMER_CYCLES + 8, n);
    for (i = 1; i < 4; i++) begin
      wr_reg(POWER_MODE_REQUEST_ADDR, 8'(i)); // halt wins when both are set
      repeat (4) @(posedge clk);
      chk(8'({osc, mon, boa, cpu, tmr, lsv}), (i == 2) ? 8'h22 : 8'h00);
      wake <= 1'b1;
      wait_lv(cpu, 1'b1, 100, n);
      wake <= 1'b0;
      chk(8'((i == 2) ? n == 5 : n >= 64 && n <= 72), 8'h01);
      chk(8'(lsv), 8'h00);
      repeat (260) @(posedge clk);
      chk(8'(lsv), 8'h01);
      rd_reg(MODE_STATUS_ADDR, 8'h0C);
      wr_reg(POWER_MODE_CLEAR_ADDR, 8'h00);
      rd_reg(MODE_STATUS_ADDR, 8'h08);
    end
    for (i = 0; i < 4; i++) begin
      wr_reg(CLOCK_CONFIG_ADDR, 8'(i));
      repeat (2) @(posedge clk);
      chk({csrc, div, 2'b0, osc}, {2'(i), (i == 0) ? 3'h2 : (i == 1) ? 3'h1 : 3'h4, 2'b0, 1'(i == 0)});
    end
    for (i = 0; i < 3; i++) begin
      src <= 3'(1 << i);
      repeat (5) @(posedge clk);
      chk(8'({sysr, ior}), 8'h03);
      src <= 3'h0;
      wait_lv(sysr, 1'b0, 200, n);
    end
    summarize;
  end
endmodule
bind power_mode_supply_monitor pwr_monitor u_mon (.CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
  .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .WATCHDOG_EXPIRE_IN(WATCHDOG_EXPIRE_IN), .THRESHOLD_SELECT_OUT(THRESHOLD_SELECT_OUT),
  .OSC_ENABLE_OUT(OSC_ENABLE_OUT), .CLOCK_SOURCE_OUT(CLOCK_SOURCE_OUT), .CLOCK_DIVIDE_OUT(CLOCK_DIVIDE_OUT),
  .CPU_RUN_OUT(CPU_RUN_OUT), .TIMER_RUN_OUT(TIMER_RUN_OUT), .IO_RESET_OUT(IO_RESET_OUT),
  .SYSTEM_RESET_OUT(SYSTEM_RESET_OUT));
